// File: pkg/cfglu_consts.vh
`ifndef CFGLU_CONSTS_VH
`define CFGLU_CONSTS_VH
// register indices on the plain port
`define CFGLU_IDX_GLOBAL_CONTROL 4'h0
`define CFGLU_IDX_SEQUENCER_SELECT 4'h1
`define CFGLU_IDX_TABLE0_MODE 4'h5
`define CFGLU_IDX_TABLE0_INPUT_SEL_AB 4'h6
`define CFGLU_IDX_TABLE0_INPUT_SEL_C 4'h7
`define CFGLU_IDX_TABLE0_PATTERN 4'h8
`define CFGLU_IDX_TABLE1_MODE 4'h9
`define CFGLU_IDX_TABLE1_INPUT_SEL_AB 4'hA
`define CFGLU_IDX_TABLE1_INPUT_SEL_C 4'hB
`define CFGLU_IDX_TABLE1_PATTERN 4'hC
// global control fields
`define CFGLU_GC_ENABLE_BIT 0
`define CFGLU_GC_RUN_IN_STANDBY_BIT 6
`define CFGLU_GC_MASK 8'h41
// table mode fields
`define CFGLU_TM_ENABLE_BIT 0
`define CFGLU_TM_PIN_OE_BIT 3
`define CFGLU_TM_FILT_LSB 4
`define CFGLU_TM_FILT_MSB 5
`define CFGLU_TM_CLOCK_SOURCE_SELECT_BIT 6
`define CFGLU_TM_EDGE_BIT 7
`define CFGLU_TM_MASK 8'hF9
`define CFGLU_SEQ_MASK 8'h0F
`define CFGLU_SEL_C_MASK 8'h0F
`define CFGLU_RESET_VALUE 8'h00
// sequencer select encodings
`define CFGLU_SEQ_OFF 4'h0
`define CFGLU_SEQ_GATED_DATA_FLIPFLOP 4'h1
`define CFGLU_SEQ_TOGGLE_CAPABLE_FLIPFLOP 4'h2
`define CFGLU_SEQ_LEVEL_DATA_LATCH 4'h3
`define CFGLU_SEQ_SET_RESET_LATCH 4'h4
// filter select encodings
`define CFGLU_FILT_OFF 2'h0
`define CFGLU_FILT_SYNCHRONIZER_OPTION 2'h1
`define CFGLU_FILT_FULL 2'h2
// input source encodings
`define CFGLU_SRC_MASK 4'h0
`define CFGLU_SRC_FEEDBACK 4'h1
`define CFGLU_SRC_LINK 4'h2
`define CFGLU_SRC_EVENT_A 4'h3
`define CFGLU_SRC_EVENT_B 4'h4
`define CFGLU_SRC_IO 4'h5
`define CFGLU_SRC_LAST 4'hE
`endif

// File: rtl/cfglu_seq.v
`timescale 1ns/1ps
`include "cfglu_consts.vh"
module cfglu_seq
(
    input wire clk_sys_in, // system clock
    input wire rst_b_in, // async reset, active low
    input wire tick_in, // selected clock edge of the even table
    input wire clear_in, // sequential reset request
    input wire [3:0] mode_in, // sequencer select field
    input wire even_in, // even table output
    input wire odd_in, // odd table output
    output wire state_out // stored output
);
    reg state_q;
    reg state_d;

    always @*
    begin
        state_d = state_q;
        case (mode_in)
            `CFGLU_SEQ_GATED_DATA_FLIPFLOP:
                if (tick_in && odd_in)
                    state_d = even_in; // [R01]
            `CFGLU_SEQ_TOGGLE_CAPABLE_FLIPFLOP:
                if (tick_in)
                begin
                    case ({even_in, odd_in}) // [R02]
                        2'h1: state_d = 1'b0;
                        2'h2: state_d = 1'b1;
                        2'h3: state_d = ~state_q;
                        default: state_d = state_q;
                    endcase
                end
            // latches are level sensitive, so they follow on every system edge
            `CFGLU_SEQ_LEVEL_DATA_LATCH:
                if (odd_in)
                    state_d = even_in; // [R03]
            `CFGLU_SEQ_SET_RESET_LATCH:
                if (even_in && !odd_in)
                    state_d = 1'b1; // [R04]
                else if (odd_in && !even_in)
                    state_d = 1'b0; // [R04]
            default:
                state_d = 1'b0; // [R23]
        endcase
        if (clear_in)
            state_d = 1'b0; // [R01] [R02] [R21]
    end

    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state_q <= 1'b0;
        else
            state_q <= state_d;
    end

    // clear shows at once, not one edge later
    assign state_out = state_q & ~clear_in; // [R21]
endmodule // cfglu_seq

// File: rtl/cfglu_table.v
`timescale 1ns/1ps
`include "cfglu_consts.vh"
module cfglu_table
(
    input wire clk_sys_in, // system clock
    input wire rst_b_in, // async reset, active low
    input wire active_in, // unit and table enabled
    input wire clock_source_select_in, // clock source select
    input wire [1:0] filt_sel_in, // filter select
    input wire edge_en_in, // edge detect enable
    input wire pclk_run_in, // peripheral clock running
    input wire [2:0] event_table_input_in, // selected inputs 2..0
    input wire [7:0] pattern_in, // truth pattern
    output wire tick_out, // selected table clock edge
    output wire uses_clock_out, // filter or edge detector in use
    output wire value_out // table value after filter and edge detector
);
    reg in2_prev_q;
    reg sync1_q;
    reg sync2_q;
    reg hist0_q;
    reg hist1_q;
    reg filt_q;
    reg edge_prev_q;
    wire in2_masked;
    wire raw;
    wire filt_val;
    wire use_filt;

    // input 2 becomes a clock edge, taken on its rising transition
    assign tick_out = clock_source_select_in ? (event_table_input_in[2] & ~in2_prev_q) : pclk_run_in; // [R05] [R13]
    assign in2_masked = clock_source_select_in ? 1'b0 : event_table_input_in[2]; // [R07]
    assign raw = pattern_in[{in2_masked, event_table_input_in[1:0]}]; // [R19] [R09]
    assign use_filt = (filt_sel_in == `CFGLU_FILT_SYNCHRONIZER_OPTION) || (filt_sel_in == `CFGLU_FILT_FULL);
    assign uses_clock_out = use_filt | edge_en_in;
    assign filt_val = (filt_sel_in == `CFGLU_FILT_FULL) ? filt_q :
                      (filt_sel_in == `CFGLU_FILT_SYNCHRONIZER_OPTION) ? sync2_q : raw; // [R17] [R23]
    assign value_out = active_in & (edge_en_in ? (filt_val & ~edge_prev_q) : filt_val); // [R18]

    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            in2_prev_q <= 1'b0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            hist0_q <= 1'b0;
            hist1_q <= 1'b0;
            filt_q <= 1'b0;
            edge_prev_q <= 1'b0;
        end
        else
        begin
            in2_prev_q <= event_table_input_in[2];
            if (!active_in)
            begin
                // internal filter and edge state is gone one cycle after disable
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
                hist0_q <= 1'b0;
                hist1_q <= 1'b0;
                filt_q <= 1'b0;
                edge_prev_q <= 1'b0;
            end
            else if (tick_out)
            begin
                sync1_q <= raw;
                sync2_q <= sync1_q;
                hist0_q <= sync2_q;
                hist1_q <= hist0_q;
                // three agreeing samples give a 4..5 cycle delay
                if (sync2_q == hist0_q && hist0_q == hist1_q)
                    filt_q <= hist1_q; // [R22]
                edge_prev_q <= filt_val;
            end
        end
    end
endmodule // cfglu_table

// File: rtl/cfglu_top.v
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "cfglu_consts.vh"
// Operation
// [R01] gated data flip-flop: even is data, odd is gate; reset clears, gate low holds.
// [R02] toggle flip-flop: even J, odd K; 00 hold, 01 clear, 10 set, 11 toggle.
// [R03] data latch: even is data, odd gate; follows while gate high, else holds.
// [R04] set/reset latch: even set, odd reset; software must avoid both high.
// [R05] clocked parts use peripheral clock, or input line 2 when clock source bit set.
// [R06] shared sequential element uses the even table's selected clock only.
// [R07] with input 2 as clock, it indexes the pattern as low.
// [R08] software disables the unit before changing any clock source.
// [R09] table values are offered as output events; input events index patterns directly.
// [R10] run-in-standby keeps the system clock requested in standby.
// [R11] without run-in-standby, clocked tables output zero in standby.
// [R12] in idle sleep the pattern decode keeps running.
// [R13] input line 2 clocks the table in every mode, sleep included.
// [R14] run-in-standby has no effect where no peripheral clock is needed.
// [R15] global control: enable at bit 0, run-in-standby at bit 6, reset zero.
// [R16] sequencer select: 0 off, 1 data flop, 2 JK, 3 latch, 4 set/reset.
// [R17] filter select: 0 none, 1 synchronizer, 2 full filter, 3 reserved.
// [R18] table mode: bit 7 edge, 6 clock source, 3 pin enable, 0 enable.
// [R19] table value is pattern bit indexed by inputs 2,1,0, input 2 high.
// [R20] protected bits writable while disabled or with the enabling write.
// [R21] disabling the even table clears the sequential element for one cycle; here it stays clear while the even table is off and one cycle after it goes off.
// [R22] full filter delays the value by two to five selected clocks; here four to five.
// [R23] reserved encodings act as disabled; unused bits read zero.
module cfglu_top
#(
    parameter NUM_TABLES = 2,
    parameter PERIPH_SRC = 16
)
(
    input wire clk_sys_in, // system clock, 25 MHz
    input wire rst_b_in, // async reset, active low
    input wire [3:0] reg_addr_in, // register index
    input wire [7:0] reg_wdata_in, // write data
    input wire reg_wr_in, // write strobe
    input wire reg_rd_in, // read strobe
    output wire [7:0] reg_rdata_out, // read data, one cycle after strobe
    input wire [3:0] event_table_input_in, // input events 0..3
    input wire [3*NUM_TABLES-1:0] io_in, // table input pins
    input wire [3*NUM_TABLES*PERIPH_SRC-1:0] periph_in, // peripheral sources by select code
    input wire standby_in, // standby sleep active
    input wire idle_in, // idle sleep active
    output wire [NUM_TABLES-1:0] table_output_event_out, // table output events
    output wire [NUM_TABLES-1:0] pin_out_out, // table pin value
    output wire [NUM_TABLES-1:0] pin_oe_out, // table pin output enable
    output wire seq_state_out, // sequential element output
    output wire clock_request_out // peripheral clock needed
);
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg glob_en_q;
    reg run_stdby_q;
    reg [3:0] sequencer_select_field_q;
    reg [7:0] mode_q [0:NUM_TABLES-1];
    reg [7:0] sel_ab_q [0:NUM_TABLES-1];
    reg [3:0] sel_c_q [0:NUM_TABLES-1];
    reg [7:0] pattern_q [0:NUM_TABLES-1];
    reg [NUM_TABLES-1:0] out_q;
    reg even_en_prev_q;
    reg seq_clr_hold_q;
    reg [3:0] widx;
    reg wr_mode;
    reg wr_sel_ab;
    reg wr_sel_c;
    reg wr_pattern;
    integer i;
    // the read decode keeps its own loop index so that only one process drives each
    integer ri;
    wire [NUM_TABLES-1:0] tick;
    wire [NUM_TABLES-1:0] uses_clk;
    wire [NUM_TABLES-1:0] value;
    wire [NUM_TABLES-1:0] active;
    wire [NUM_TABLES-1:0] needs_pclk;
    wire [NUM_TABLES-1:0] forced_low;
    wire pclk_run;
    wire seq_on;
    wire seq_state;
    wire seq_clr;
    wire idle_unused;

    // index of a table's first register
    function [3:0] table_base;
        input integer t;
        begin
            table_base = (t == 0) ? `CFGLU_IDX_TABLE0_MODE : `CFGLU_IDX_TABLE1_MODE;
        end
    endfunction

    // selects one table input; link and feedback use registered values to break loops
    function pick_src;
        input [3:0] sel;
        input fb;
        input lnk;
        input ev_a;
        input ev_b;
        input io;
        input [PERIPH_SRC-1:0] per;
        begin
            case (sel)
                `CFGLU_SRC_MASK: pick_src = 1'b0;
                `CFGLU_SRC_FEEDBACK: pick_src = fb;
                `CFGLU_SRC_LINK: pick_src = lnk;
                `CFGLU_SRC_EVENT_A: pick_src = ev_a; // [R09]
                `CFGLU_SRC_EVENT_B: pick_src = ev_b; // [R09]
                `CFGLU_SRC_IO: pick_src = io;
                default: pick_src = (sel <= `CFGLU_SRC_LAST) ? per[sel] : 1'b0;
            endcase
        end
    endfunction

    always @*
    begin
        widx = reg_addr_in;
        wr_mode = 1'b0;
        wr_sel_ab = 1'b0;
        wr_sel_c = 1'b0;
        wr_pattern = 1'b0;
    end

    // register writes
    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            glob_en_q <= 1'b0; // [R15]
            run_stdby_q <= 1'b0; // [R15]
            sequencer_select_field_q <= `CFGLU_SEQ_OFF;
            for (i = 0; i < NUM_TABLES; i = i + 1)
            begin
                mode_q[i] <= `CFGLU_RESET_VALUE;
                sel_ab_q[i] <= `CFGLU_RESET_VALUE;
                sel_c_q[i] <= 4'h0;
                pattern_q[i] <= `CFGLU_RESET_VALUE;
            end
        end
        else if (reg_wr_in)
        begin
            if (widx == `CFGLU_IDX_GLOBAL_CONTROL)
            begin
                glob_en_q <= reg_wdata_in[`CFGLU_GC_ENABLE_BIT]; // [R15]
                run_stdby_q <= reg_wdata_in[`CFGLU_GC_RUN_IN_STANDBY_BIT]; // [R15]
            end
            if (widx == `CFGLU_IDX_SEQUENCER_SELECT && !mode_q[0][`CFGLU_TM_ENABLE_BIT])
                sequencer_select_field_q <= reg_wdata_in[3:0]; // [R20]
            for (i = 0; i < NUM_TABLES; i = i + 1)
            begin
                if (widx == table_base(i))
                begin
                    // protected bits go in while disabled or with the enabling write
                    if (!mode_q[i][`CFGLU_TM_ENABLE_BIT] || reg_wdata_in[`CFGLU_TM_ENABLE_BIT])
                        mode_q[i] <= reg_wdata_in & `CFGLU_TM_MASK; // [R20] [R23]
                    else
                        mode_q[i] <= mode_q[i] & ~(8'h01 << `CFGLU_TM_ENABLE_BIT); // [R20]
                end
                if (!mode_q[i][`CFGLU_TM_ENABLE_BIT])
                begin
                    if (widx == table_base(i) + 4'h1)
                        sel_ab_q[i] <= reg_wdata_in; // [R20]
                    if (widx == table_base(i) + 4'h2)
                        sel_c_q[i] <= reg_wdata_in[3:0]; // [R20]
                    if (widx == table_base(i) + 4'h3)
                        pattern_q[i] <= reg_wdata_in; // [R20]
                end
            end
        end
    end

    // register reads
    always @*
    begin
        rdata_d = 8'h00; // [R23]
        if (reg_addr_in == `CFGLU_IDX_GLOBAL_CONTROL)
        begin
            rdata_d[`CFGLU_GC_ENABLE_BIT] = glob_en_q;
            rdata_d[`CFGLU_GC_RUN_IN_STANDBY_BIT] = run_stdby_q;
        end
        if (reg_addr_in == `CFGLU_IDX_SEQUENCER_SELECT)
            rdata_d = {4'h0, sequencer_select_field_q};
        for (ri = 0; ri < NUM_TABLES; ri = ri + 1)
        begin
            if (reg_addr_in == table_base(ri))
                rdata_d = mode_q[ri];
            if (reg_addr_in == table_base(ri) + 4'h1)
                rdata_d = sel_ab_q[ri];
            if (reg_addr_in == table_base(ri) + 4'h2)
                rdata_d = {4'h0, sel_c_q[ri]};
            if (reg_addr_in == table_base(ri) + 4'h3)
                rdata_d = pattern_q[ri];
        end
    end

    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_q <= 8'h00;
        else if (reg_rd_in)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_out = rdata_q;

    // the peripheral clock stops in standby unless asked to run
    assign pclk_run = ~standby_in | run_stdby_q; // [R10]
    // idle sleep leaves the decode path untouched
    assign idle_unused = idle_in; // [R12]
    assign seq_on = (sequencer_select_field_q == `CFGLU_SEQ_GATED_DATA_FLIPFLOP) ||
                    (sequencer_select_field_q == `CFGLU_SEQ_TOGGLE_CAPABLE_FLIPFLOP) ||
                    (sequencer_select_field_q == `CFGLU_SEQ_LEVEL_DATA_LATCH) ||
                    (sequencer_select_field_q == `CFGLU_SEQ_SET_RESET_LATCH); // [R16] [R23]

    genvar g;
    generate
        for (g = 0; g < NUM_TABLES; g = g + 1)
        begin : gen_table
            wire [2:0] ins;
            wire lnk;
            wire [3*PERIPH_SRC-1:0] per;
            assign lnk = out_q[(g + 1) % NUM_TABLES];
            assign per = periph_in[3*PERIPH_SRC*g +: 3*PERIPH_SRC];
            assign ins[0] = pick_src(sel_ab_q[g][3:0], seq_state, lnk, event_table_input_in[g],
                                     event_table_input_in[g+2], io_in[3*g], per[0 +: PERIPH_SRC]);
            assign ins[1] = pick_src(sel_ab_q[g][7:4], seq_state, lnk, event_table_input_in[g],
                                     event_table_input_in[g+2], io_in[3*g+1], per[PERIPH_SRC +: PERIPH_SRC]);
            assign ins[2] = pick_src(sel_c_q[g], seq_state, lnk, event_table_input_in[0],
                                     event_table_input_in[1], io_in[3*g+2], per[2*PERIPH_SRC +: PERIPH_SRC]);
            assign active[g] = glob_en_q & mode_q[g][`CFGLU_TM_ENABLE_BIT]; // [R18]

            cfglu_table u_table
            (
                .clk_sys_in(clk_sys_in),
                .rst_b_in(rst_b_in),
                .active_in(active[g]),
                .clock_source_select_in(mode_q[g][`CFGLU_TM_CLOCK_SOURCE_SELECT_BIT]), // [R18]
                .filt_sel_in(mode_q[g][`CFGLU_TM_FILT_MSB:`CFGLU_TM_FILT_LSB]),
                .edge_en_in(mode_q[g][`CFGLU_TM_EDGE_BIT]), // [R18]
                .pclk_run_in(pclk_run),
                .event_table_input_in(ins),
                .pattern_in(pattern_q[g]),
                .tick_out(tick[g]),
                .uses_clock_out(uses_clk[g]),
                .value_out(value[g])
            );

            // sequencer counts as clocked use for both tables of the pair
            assign needs_pclk[g] = active[g] & ~mode_q[g][`CFGLU_TM_CLOCK_SOURCE_SELECT_BIT] & (uses_clk[g] | seq_on); // [R14]
            assign forced_low[g] = standby_in & ~run_stdby_q & (uses_clk[g] | seq_on)
                                   & ~mode_q[g][`CFGLU_TM_CLOCK_SOURCE_SELECT_BIT]; // [R11]

            always @(posedge clk_sys_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                    out_q[g] <= 1'b0;
                else
                    out_q[g] <= value[g] & ~forced_low[g]; // [R09] [R11] [R12]
            end

            assign pin_out_out[g] = out_q[g];
            assign pin_oe_out[g] = active[g] & mode_q[g][`CFGLU_TM_PIN_OE_BIT]; // [R18]
        end
    endgenerate

    // clear while the even table is off, plus one cycle after it goes off
    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            even_en_prev_q <= 1'b0;
            seq_clr_hold_q <= 1'b0;
        end
        else
        begin
            even_en_prev_q <= active[0];
            seq_clr_hold_q <= even_en_prev_q & ~active[0]; // [R21]
        end
    end

    assign seq_clr = ~active[0] | seq_clr_hold_q; // [R21]

    cfglu_seq u_seq
    (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .tick_in(tick[0]), // [R06]
        .clear_in(seq_clr),
        .mode_in(sequencer_select_field_q), // [R16]
        .even_in(value[0] & ~forced_low[0]),
        .odd_in(value[1] & ~forced_low[1]),
        .state_out(seq_state)
    );

    assign seq_state_out = seq_state;
    assign table_output_event_out = out_q; // [R09]
    // a purely combinational setup never requests the clock
    assign clock_request_out = glob_en_q & (|needs_pclk) & pclk_run & ~(idle_unused & 1'b0); // [R10] [R14]
endmodule // cfglu_top

// File: test/cfglu_top_sva.sv
`timescale 1ns/1ps
module cfglu_top_sva
#(
    parameter NUM_TABLES = 2,
    parameter PERIPH_SRC = 16
)
(
    input wire clk_sys_in, // clock
    input wire rst_b_in, // reset
    input wire [3:0] reg_addr_in, // index
    input wire [7:0] reg_wdata_in, // data
    input wire reg_wr_in, // write
    input wire reg_rd_in, // read
    input wire [7:0] reg_rdata_out, // read data
    input wire standby_in, // standby
    input wire [NUM_TABLES-1:0] table_output_event_out, // events
    input wire [NUM_TABLES-1:0] pin_out_out, // pins
    input wire [NUM_TABLES-1:0] pin_oe_out, // pin enables
    input wire seq_state_out, // sequencer
    input wire clock_request_out // clock request
);
    reg gen_q;
    reg rsb_q;
    reg en0_q;
    // enable bits are never protected, so a plain shadow tracks them
    always @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            gen_q <= 1'b0;
            rsb_q <= 1'b0;
            en0_q <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == 4'h0)
        begin
            gen_q <= reg_wdata_in[0];
            rsb_q <= reg_wdata_in[6];
        end
        else if (reg_wr_in && reg_addr_in == 4'h5)
            en0_q <= reg_wdata_in[0];
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_reads_zero: assert property ($past(reg_rd_in) && ($past(reg_addr_in) inside {4'h2, 4'h3, 4'h4,
        4'hD, 4'hE, 4'hF}) |-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_global_readback: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h0 |->
        reg_rdata_out == {1'b0, $past(rsb_q), 5'h00, $past(gen_q)}) else $error("global control readback");
    a_sequencer_select_field_upper_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h1 |->
        reg_rdata_out[7:4] == 4'h0) else $error("sequencer select upper bits");
    a_mode_gap_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h5 |->
        reg_rdata_out[2:1] == 2'b00) else $error("mode unused bits");
    a_oe_needs_enable: assert property (pin_oe_out[0] |-> gen_q && en0_q)
        else $error("pin enable while disabled");
    a_pin_tracks_event: assert property (pin_out_out == table_output_event_out)
        else $error("pin and event differ");
    a_seq_clear_idle: assert property (!(gen_q && en0_q) |-> !seq_state_out)
        else $error("sequencer not cleared");
    a_events_off: assert property (!gen_q && !$past(gen_q) |-> table_output_event_out == '0)
        else $error("event while unit disabled");
    a_clkreq_standby: assert property (standby_in && !rsb_q || !gen_q |-> !clock_request_out)
        else $error("clock requested in standby");
endmodule // cfglu_top_sva
bind cfglu_top cfglu_top_sva #(.NUM_TABLES(NUM_TABLES), .PERIPH_SRC(PERIPH_SRC)) u_sva (.clk_sys_in, .rst_b_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .standby_in, .table_output_event_out,
    .pin_out_out, .pin_oe_out, .seq_state_out, .clock_request_out);

// File: test/test_lookup_pair_sequencer.sv
`timescale 1ns/1ps
module test_lookup_pair_sequencer;
    reg clk_sys_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg [3:0] reg_addr_in = 4'h0;
    reg [7:0] reg_wdata_in = 8'h00;
    reg reg_wr_in = 1'b0;
    reg reg_rd_in = 1'b0;
    reg [3:0] event_table_input_in = 4'h0;
    reg [5:0] io_in = 6'h00;
    reg [95:0] periph_in = 96'h0;
    reg standby_in = 1'b0;
    reg idle_in = 1'b0;
    wire [7:0] reg_rdata_out;
    wire [1:0] table_output_event_out;
    wire [1:0] pin_out_out;
    wire [1:0] pin_oe_out;
    wire seq_state_out;
    wire clock_request_out;
    reg [7:0] m [0:15];
    integer errors = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer i;
    integer k;
    reg s;
    reg [1:0] j;
    cfglu_top #(.NUM_TABLES(2), .PERIPH_SRC(16)) i_dut (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .event_table_input_in, .io_in, .periph_in, .standby_in,
        .idle_in, .table_output_event_out, .pin_out_out, .pin_oe_out, .seq_state_out, .clock_request_out);
    initial
    begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task report_and_stop;
    begin
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    always @(posedge clk_sys_in)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            $display("ERROR %0t timeout", $time);
            report_and_stop;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // model updated at issue; every check comes later than the write edge
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        if (a == 4'h0)
            m[0] = d & 8'h41;
        else if (a == 4'h5 || a == 4'h9)
            m[a] = (m[a][0] && !d[0]) ? (m[a] & 8'hFE) : (d & 8'hF9);
        else if (a == 4'h1 && !m[5][0])
            m[1] = d & 8'h0F;
        else if (a >= 4'h6 && a <= 4'hC && !m[(a < 4'h9) ? 5 : 9][0])
            m[a] = d & ((a == 4'h7 || a == 4'hB) ? 8'h0F : 8'hFF);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    end
    endtask
    task rd(input [3:0] a);
    begin
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, m[a]);
    end
    endtask
    function lookup_table(input t, input [3:0] e);
        reg [2:0] x;
        reg [7:0] c;
    begin
        c = m[t ? 9 : 5];
        x = t ? {e[0] & !c[6], e[3], e[1]} : {e[1] & !c[6], e[2], e[0]};
        lookup_table = m[0][0] & c[0] & m[t ? 12 : 8][x];
    end
    endfunction
    task dchk;
    begin
        @(posedge clk_sys_in);
        event_table_input_in <= 4'($urandom);
        repeat (2) @(posedge clk_sys_in);
        #1 chk({4'h0, table_output_event_out, pin_out_out}, {4'h0, {2{lookup_table(1, event_table_input_in),
            lookup_table(0, event_table_input_in)}}});
        chk({6'h00, pin_oe_out}, {6'h00, m[0][0] & m[9][0] & m[9][3], m[0][0] & m[5][0] & m[5][3]});
    end
    endtask
    initial
    begin
        for (i = 0; i < 16; i = i + 1)
            m[i] = 8'h00;
        k = $urandom(67);
        repeat (16) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        for (i = 0; i < 16; i = i + 1)
            rd(i[3:0]);
        wr(4'h0, 8'hFF);
        rd(4'h0);
        $display("test reset values done");
        wr(4'h6, 8'h43);
        wr(4'h7, 8'h04);
        wr(4'hA, 8'h43);
        wr(4'hB, 8'h03);
        wr(4'hC, 8'($urandom));
        wr(4'h9, 8'h09);
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(4'h0, 8'h00);
            wr(4'h5, 8'h00);
            wr(4'h8, 8'($urandom));
            wr(4'h5, i == 0 ? 8'h01 : (i == 1 ? 8'h41 : 8'h09));
            wr(4'h0, 8'h01);
            rd(4'h5);
            for (k = 0; k < 8; k = k + 1)
                dchk;
        end
        $display("test decode done");
        wr(4'h8, 8'h5A);
        wr(4'h7, 8'hF4);
        wr(4'hE, 8'hFF);
        wr(4'h5, 8'hF8);
        for (i = 5; i < 15; i = i + 3)
            rd(i[3:0]);
        wr(4'h7, 8'hF4);
        rd(4'h7);
        wr(4'h7, 8'h04);
        $display("test protection done");
        wr(4'h8, 8'hAA);
        wr(4'h9, 8'h00);
        wr(4'hC, 8'hAA);
        wr(4'h9, 8'h01);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(4'h5, 8'h00);
            wr(4'h1, i[7:0]);
            wr(4'h5, 8'h01);
            s = 1'b0;
            for (k = 0; k < 10; k = k + 1)
            begin
                j = 2'($urandom);
                if (i == 4 && j == 2'b11)
                    j = 2'b10;
                @(posedge clk_sys_in);
                event_table_input_in <= {2'b00, j};
                @(posedge clk_sys_in);
                event_table_input_in <= 4'h0;
                if (i == 2)
                    s = (j == 2'b11) ? ~s : ((j == 2'b00) ? s : j[0]);
                else if (i == 4)
                    s = j[0] | (s & !j[1]);
                else if (j[1])
                    s = j[0];
                repeat (3) @(posedge clk_sys_in);
                #1 chk({7'h00, seq_state_out}, {7'h00, s & (i > 0 && i < 5)});
            end
        end
        $display("test sequencer done");
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(4'h5, 8'h00);
            wr(4'h5, {i[1], 1'b0, i[1:0], 4'h1});
            @(posedge clk_sys_in);
            #1 chk({7'h00, clock_request_out}, {7'h00, i > 0});
        end
        wr(4'h5, 8'h00);
        wr(4'h5, 8'h21);
        standby_in <= 1'b1;
        event_table_input_in <= 4'h1;
        repeat (8) @(posedge clk_sys_in);
        #1 chk({6'h00, clock_request_out, table_output_event_out[0]}, 8'h00);
        wr(4'h0, 8'h41);
        @(posedge clk_sys_in);
        #1 chk({6'h00, clock_request_out, table_output_event_out[0]}, 8'h02);
        repeat (7) @(posedge clk_sys_in);
        #1 chk({6'h00, clock_request_out, table_output_event_out[0]}, 8'h03);
        wr(4'h0, 8'h01);
        wr(4'h5, 8'h00);
        wr(4'h5, 8'h09);
        idle_in <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            dchk;
        chk({7'h00, clock_request_out}, 8'h00);
        $display("test sleep done");
        report_and_stop;
    end
endmodule // test_lookup_pair_sequencer
